// ---- timer_counter.sv ----
`timescale 1ns/100ps
`default_nettype none
// Contract
// RULE_01: source clear: count every instruction cycle
// RULE_02: count write inhibits two instruction cycles
// RULE_03: source set: count pin edge, selectable
// RULE_04: prescaler goes to timer or watchdog
// RULE_05: ratio field selects 1:2 to 1:256
// RULE_06: rollover ff to 00 sets overflow flag
// RULE_07: enable bit masks request, flag still set
// RULE_08: software clears flag, hardware never does
// RULE_09: timer stops while device sleeps
// RULE_10: flag sampled each cycle, latency three cycles
// RULE_11: pin sampled on second, fourth phase
// RULE_12: unscaled pin high/low at least 2 periods
// RULE_13: scaled pin period at least 4 periods/ratio
// RULE_14: count updates 3 to 7 periods after edge
// RULE_15: count write clears prescaler when timer owns it
// RULE_16: watchdog clear clears prescaler when watchdog owns
// RULE_17: eight bit prescaler, invisible to software
// RULE_18: software follows sequence moving prescaler
// RULE_19: ratio is two to power n plus one
module timer_counter
  import tmr_pkg::*;
#(
  parameter int PS_WIDTH = 8
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external timer clock pin
  input wire logic timer_external_clock_pin,
  // watchdog side
  input wire logic wdt_tick_i,
  output logic wdt_clear_o,
  output logic wdt_tick_o,
  // overflow interrupt request
  output logic irq_o
);

  // registers
  logic [7:0] timer_count_register_q;
  logic [7:0] option_q;
  logic timer_overflow_flag_q;
  logic timer_overflow_irq_enable_q;
  logic sleep_q;
  phase_t phase_q;
  logic [PS_WIDTH-1:0] prescaler_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic src_prev_q;
  logic [1:0] inhibit_q;
  logic [IRQ_LATENCY-1:0] irq_pipe_q;
  logic flag_seen_q;
  logic wdt_clear_q;
  logic wdt_tick_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // ratio select: tap n of the prescaler gives 2^(n+1)
  function automatic logic tap(input logic [PS_WIDTH-1:0] cnt, input logic [2:0] n);
    tap = cnt[n];
  endfunction

  // bus decode
  wire logic acc = psel && penable && !pready_q;
  wire logic wr = acc && pwrite;
  wire logic hit_count = (paddr == OFS_COUNT);
  wire logic hit_option = (paddr == OFS_OPTION);
  wire logic hit_intctl = (paddr == OFS_INTCTL);
  wire logic hit_ctrl = (paddr == OFS_CTRL);
  wire logic mapped = hit_count || hit_option || hit_intctl || hit_ctrl;
  wire logic wr_count = wr && hit_count;
  wire logic wr_intctl = wr && hit_intctl;
  wire logic wr_option = wr && hit_option;
  wire logic wr_ctrl = wr && hit_ctrl;
  wire logic wd_clear_cmd = wr && hit_ctrl && pwdata[CTRL_WDCLR_BIT];

  // option fields
  wire opt_t opt = '{
    src: option_q[OPT_SRC_BIT],
    edge_fall: option_q[OPT_EDGE_BIT],
    prescaler_assign_bit: option_q[OPT_PSA_BIT],
    ps: option_q[OPT_PS_LSB +: 3]
  };
  wire logic ps_to_timer = !opt.prescaler_assign_bit; // [RULE_04]

  // cycle boundary: last phase of an instruction cycle
  wire logic cyc_end = (phase_q == PH4);
  wire logic sample_ph = (phase_q == PH2) || (phase_q == PH4); // [RULE_11]

  // edge detection on the synchronized pin; both stages idle low after reset,
  // so a pin held high through reset shows one rising edge after it; a change of edge select adds no edge
  wire logic pin_rise = pin_s2_q && !src_prev_q;
  wire logic pin_fall = !pin_s2_q && src_prev_q;
  wire logic pin_edge = opt.edge_fall ? pin_fall : pin_rise; // [RULE_03]

  // prescaler input: pin edge in counter mode, cycle tick in timer mode
  wire logic ps_in = opt.src ? pin_edge : cyc_end; // [RULE_01] [RULE_03]
  wire logic ps_next_bit = tap(prescaler_q + PS_WIDTH'(1), opt.ps);
  wire logic ps_rise = ps_in && ps_next_bit && !tap(prescaler_q, opt.ps);
  // prescaler carry into the timer, or raw source when unassigned
  wire logic timer_src = ps_to_timer ? ps_rise : ps_in; // [RULE_05] [RULE_19]
  wire logic timer_inc = timer_src && !sleep_q && (inhibit_q == 2'd0); // [RULE_02] [RULE_09]
  wire logic rollover = timer_inc && (timer_count_register_q == 8'hff); // [RULE_06]
  // prescaler advances on watchdog ticks when watchdog owns it
  wire logic wd_ps_in = !ps_to_timer && wdt_tick_i;
  wire logic wd_ps_out = wd_ps_in && ps_next_bit && !tap(prescaler_q, opt.ps);
  wire logic ps_clear = (wr_count && ps_to_timer) || (wd_clear_cmd && !ps_to_timer);

  // read words, each register sits in the low byte
  wire logic [31:0] rd_count_w = {24'h0, timer_count_register_q};
  wire logic [31:0] rd_option_w = {24'h0, option_q};
  wire logic [31:0] rd_intctl_w =
    {26'h0, timer_overflow_irq_enable_q, 2'b00, timer_overflow_flag_q, 2'b00};
  wire logic [31:0] rd_ctrl_w = {31'h0, sleep_q};
  // read data mux; the prescaler is never visible
  wire logic [31:0] rd_mux =
    hit_count ? rd_count_w :
    hit_option ? rd_option_w :
    hit_intctl ? rd_intctl_w :
    hit_ctrl ? rd_ctrl_w : 32'h0; // [RULE_17]
  // masked overflow request, the flag keeps the event either way
  wire logic irq_req = timer_overflow_flag_q && timer_overflow_irq_enable_q; // [RULE_07]

  // phase sequencer, gray order
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      phase_q <= PH1;
    end else begin
      case (phase_q)
        PH1: phase_q <= PH2;
        PH2: phase_q <= PH3;
        PH3: phase_q <= PH4;
        PH4: phase_q <= PH1;
        default: phase_q <= PH1;
      endcase
    end
  end

  // pin synchronizer; second stage sampled on phases two and four
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= timer_external_clock_pin;
      if (sample_ph) begin
        pin_s2_q <= pin_s1_q; // [RULE_11] [RULE_14]
      end
    end
  end

  // previous synchronized level for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= pin_s2_q;
    end
  end

  // shared eight bit prescaler
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      prescaler_q <= '0;
    end else if (ps_clear) begin
      prescaler_q <= '0; // [RULE_15] [RULE_16]
    end else if ((ps_to_timer && ps_in && !sleep_q) || wd_ps_in) begin
      prescaler_q <= prescaler_q + PS_WIDTH'(1); // [RULE_17]
    end
  end

  // count register: a write loads it, otherwise it steps on an increment
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      timer_count_register_q <= 8'h00;
    end else if (wr_count) begin
      timer_count_register_q <= pwdata[7:0];
    end else if (timer_inc) begin
      timer_count_register_q <= timer_count_register_q + 8'h01; // [RULE_01]
    end
  end

  // write inhibit: counts down instruction cycle ends after a count write
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      inhibit_q <= 2'd0;
    end else if (wr_count) begin
      inhibit_q <= 2'(WRITE_INHIBIT); // [RULE_02]
    end else if (cyc_end && inhibit_q != 2'd0) begin
      inhibit_q <= inhibit_q - 2'd1;
    end
  end

  // option register
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      option_q <= OPTION_RST;
    end else if (wr_option) begin
      option_q <= pwdata[7:0];
    end
  end

  // sleep control, stops the timer while set
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sleep_q <= 1'b0;
    end else if (wr_ctrl) begin
      sleep_q <= pwdata[CTRL_SLEEP_BIT]; // [RULE_09]
    end
  end

  // overflow interrupt enable
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      timer_overflow_irq_enable_q <= 1'b0;
    end else if (wr_intctl) begin
      timer_overflow_irq_enable_q <= pwdata[INT_EN_BIT]; // [RULE_07]
    end
  end

  // overflow flag: set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      timer_overflow_flag_q <= 1'b0;
    end else if (rollover) begin
      timer_overflow_flag_q <= 1'b1; // [RULE_06] [RULE_07]
    end else if (wr_intctl) begin
      timer_overflow_flag_q <= pwdata[INT_FLAG_BIT]; // [RULE_08]
    end
  end

  // masked request sampled once per instruction cycle
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      flag_seen_q <= 1'b0;
    end else if (cyc_end) begin
      flag_seen_q <= irq_req; // [RULE_10]
    end
  end

  // request pipe, three instruction cycles of latency
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      irq_pipe_q <= '0;
    end else if (cyc_end) begin
      irq_pipe_q <= {irq_pipe_q[IRQ_LATENCY-2:0], flag_seen_q}; // [RULE_10]
    end
  end

  // watchdog clear command pulse
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= wd_clear_cmd; // [RULE_16]
    end
  end

  // watchdog tick, through the postscaler when the watchdog owns it
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wdt_tick_q <= 1'b0;
    end else begin
      wdt_tick_q <= opt.prescaler_assign_bit ? wd_ps_out : wdt_tick_i; // [RULE_04]
    end
  end

  // apb answer: one wait state, error on unmapped address
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc;
      pslverr_q <= acc && !mapped;
    end
  end

  // read data captured on the access edge, stands with ready
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      prdata_q <= 32'h0;
    end else if (acc && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign wdt_clear_o = wdt_clear_q;
  assign wdt_tick_o = wdt_tick_q;
  assign irq_o = irq_pipe_q[IRQ_LATENCY-1];

endmodule
`default_nettype wire

// ---- tmr_pkg.sv ----
package tmr_pkg;
  // register offsets on the apb bus (byte addresses)
  localparam logic [7:0] OFS_COUNT = 8'h00;
  localparam logic [7:0] OFS_OPTION = 8'h04;
  localparam logic [7:0] OFS_INTCTL = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  // option register field positions
  localparam int OPT_SRC_BIT = 5;
  localparam int OPT_EDGE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_LSB = 0;
  localparam logic [7:0] OPTION_RST = 8'hff;
  // interrupt control register field positions
  localparam int INT_EN_BIT = 5;
  localparam int INT_FLAG_BIT = 2;
  // control register: bit0 sleep, bit1 watchdog clear (self clearing)
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_WDCLR_BIT = 1;
  // oscillator periods per instruction cycle (four phase clocks)
  localparam int PHASES = 4;
  localparam int WRITE_INHIBIT = 2;
  localparam int IRQ_LATENCY = 3;

  // four phase clocks of one instruction cycle
  typedef enum logic [1:0] {
    PH1 = 2'b00,
    PH2 = 2'b01,
    PH3 = 2'b11,
    PH4 = 2'b10
  } phase_t;

  // option fields decoded
  typedef struct packed {
    logic src;
    logic edge_fall;
    logic prescaler_assign_bit;
    logic [2:0] ps;
  } opt_t;
endpackage

// ---- timer_counter_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer_counter_props
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // apb and side outputs
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic wdt_clear_o,
  input wire logic irq_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // address decode and watchdog clear request
  wire bad_a = paddr > OFS_CTRL || paddr[1:0] != 2'h0;
  wire clr_w = psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_WDCLR_BIT];
  AST_ACK_WAIT: assert property ($rose(psel && penable) |=> pready)
    else $error("ack late");
  AST_RDY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_RDY_ACCESS: assert property (pready |-> psel && penable)
    else $error("stray ready");
  AST_ERR_MAP: assert property (pready |-> pslverr == bad_a)
    else $error("error flag wrong");
  AST_ERR_RD0: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_UPPER0: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  AST_WDCLR: assert property (wdt_clear_o |-> $past(clr_w) || $past(clr_w, 2))
    else $error("clear without cause");
  AST_WDCLR_PULSE: assert property (wdt_clear_o |=> !wdt_clear_o)
    else $error("clear held");
  AST_RST_OUT: assert property ($rose(rstn_i) |-> !irq_o && !pready && !wdt_clear_o)
    else $error("outputs after reset");
endmodule
bind timer_counter timer_counter_props props_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .wdt_clear_o(wdt_clear_o),
  .irq_o(irq_o));
`default_nettype wire

// ---- pin_clock_src.sv ----
`timescale 1ns/100ps
`default_nettype none
module pin_clock_src (
  // clock and run control
  input wire logic sys_clk_i,
  input wire logic run_i,
  // driven pin, stands still while stopped
  output logic pin_o
);
  logic [1:0] cnt_q;
  initial pin_o = 1'b0;
  // toggle every third clock: high and low last 3 periods each
  always @(posedge sys_clk_i) begin
    cnt_q <= (run_i && cnt_q != 2'h2) ? cnt_q + 2'h1 : 2'h0;
    if (run_i && cnt_q == 2'h2)
      pin_o <= !pin_o;
  end
endmodule
`default_nettype wire

// ---- timer_counter_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module timer_counter_tb;
  import tmr_pkg::*;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic run = 1'b0, tick = 1'b0, pready, pslverr, pin, wclr, wtick, irq, err;
  logic [7:0] paddr = 8'h00, va, d;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_errors = 0, checks_done = 0, cyc = 0, nclr = 0, ts, ca, k;
  // clock, cycle count and watchdog clear pulses seen
  always #4 sys_clk_i = !sys_clk_i;
  always @(posedge sys_clk_i) cyc <= cyc + 1;
  always @(posedge sys_clk_i) nclr <= nclr + int'(wclr);
  timer_counter dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_external_clock_pin(pin), .wdt_tick_i(tick),
    .wdt_clear_o(wclr), .wdt_tick_o(wtick), .irq_o(irq));
  pin_clock_src src_u (.sys_clk_i(sys_clk_i), .run_i(run), .pin_o(pin));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    ts = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  // count growth over a span, r clocks per step, s steps held back
  task automatic rate(input logic wr, input int w, input int r, input int s);
    apb(wr, OFS_COUNT, 32'h40);
    va = wr ? 8'h40 : rd[7:0];
    ca = ts;
    idle(w);
    apb(1'b0, OFS_COUNT, 32'h0);
    k = ts - ca;
    d = rd[7:0] - va;
    chk(32'(d == k / r - s || d == (k + r - 1) / r - s), 32'h1);
  endtask
  task automatic ticks;
    k = 0;
    repeat (64) begin
      @(posedge sys_clk_i);
      tick <= !tick;
      k += int'(wtick);
    end
  endtask
  task automatic t_reset;
    apb(1'b0, OFS_OPTION, 32'h0);
    chk(rd, 32'(OPTION_RST));
    apb(1'b0, OFS_INTCTL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask
  task automatic t_rates;
    apb(1'b1, OFS_OPTION, 32'h08);
    rate(1'b0, 40, 4, 0);
    rate(1'b1, 40, 4, 2);
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, OFS_OPTION, 32'(n));
      rate(1'b0, 32 << n, 8 << n, 0);
    end
  endtask
  task automatic t_ovf;
    apb(1'b1, OFS_OPTION, 32'h08);
    apb(1'b1, OFS_COUNT, 32'hfe);
    idle(30);
    apb(1'b0, OFS_INTCTL, 32'h0);
    chk({rd[30:0], irq}, {31'h04, 1'b0});
    apb(1'b1, OFS_INTCTL, 32'h24);
    for (k = 0; k < 40 && irq !== 1'b1; k++)
      @(posedge sys_clk_i);
    chk(32'(k >= 10 && k <= 16), 32'h1);
    apb(1'b1, OFS_INTCTL, 32'h20);
    idle(20);
    apb(1'b0, OFS_INTCTL, 32'h0);
    chk({rd[30:0], irq}, {31'h20, 1'b0});
  endtask
  task automatic t_sleep;
    apb(1'b1, OFS_CTRL, 32'h1);
    rate(1'b0, 200, 1 << 30, 0);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask
  // rising then falling edges: 33 clocks give 6 of the chosen kind
  task automatic t_pin;
    for (int e = 0; e < 2; e++) begin
      apb(1'b1, OFS_OPTION, e ? 32'h38 : 32'h28);
      apb(1'b0, OFS_COUNT, 32'h0);
      va = rd[7:0];
      run <= 1'b1;
      idle(33);
      run <= 1'b0;
      idle(10);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk(rd[7:0] - va, 32'h6);
    end
  endtask
  task automatic t_wdt;
    apb(1'b1, OFS_OPTION, 32'h00);
    ticks();
    chk(32'(k >= 30 && k <= 33), 32'h1);
    // move the prescaler to the watchdog by the clearing sequence
    apb(1'b1, OFS_COUNT, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h2);
    apb(1'b1, OFS_OPTION, 32'h0f);
    ticks();
    chk(32'(k <= 1), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h2);
    idle(4);
    chk(32'(nclr), 32'h2);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // main sequence after reset
  initial begin
    idle(5);
    rstn_i <= 1'b1;
    t_reset();
    t_rates();
    t_ovf();
    t_sleep();
    t_pin();
    t_wdt();
    report_and_stop();
  end
  initial begin
    idle(60000);
    n_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
